// [bench/szb_core_model.sv]
// Core bus partner: issues one request, times it and counts bus phases
`timescale 1ns/100ps
module szb_core_model (
    input  wire logic        pclk,
    output logic             core_req,
    output logic      [23:0] core_addr,
    output logic             core_write,
    output logic             core_wide,
    input  wire logic        core_done,
    input  wire logic        internal_wait_cycle,
    input  wire logic        bus_data_phase,
    input  wire logic        burst_wait_cycle,
    input  wire logic        bus_hold_cycle,
    input  wire logic        bus_idle_cycle
);
    // No request at time zero
    initial begin
        core_req = 1'b0;
        core_addr = 24'h0;
        core_write = 1'b0;
        core_wide = 1'b0;
    end
    // Result bytes: cycles, waits, data, burst waits, holds, idles
    task automatic access(input logic [23:0] a, input logic w, input logic wd, output logic [47:0] r);
        r = '0;
        @(posedge pclk);
        core_req <= 1'b1;
        core_addr <= a;
        core_write <= w;
        core_wide <= wd;
        // Request held until done is sampled or 60 cycles have passed
        do begin
            @(posedge pclk);
            r[47:40] += 8'h1;
            r[39:32] += 8'(internal_wait_cycle);
            r[31:24] += 8'(bus_data_phase);
            r[23:16] += 8'(burst_wait_cycle);
            r[15:8] += 8'(bus_hold_cycle);
            r[7:0] += 8'(bus_idle_cycle);
        end while (core_done !== 1'b1 && r[47:40] < 8'd60);
        core_req <= 1'b0;
        core_addr <= ~a; // Released address lines lose their last value
    endtask
endmodule

// [bench/szb_static_zone_bus_timing_bench.sv]
// Bench: registers over APB, then timed core bus cycles per zone setting
`timescale 1ns/100ps
module szb_static_zone_bus_timing_bench;
    import szb_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready, pslverr, core_req, core_write, core_wide, core_done, bus_write, bus_byte_hi, bus_wide;
    logic        zone0_select, zone1_select_out_n, zone2_select_out_n, io_select_n, bus_addr_phase;
    logic        internal_wait_cycle, bus_data_phase, burst_wait_cycle, bus_hold_cycle, bus_idle_cycle;
    logic [23:0] core_addr;
    logic [31:0] rd;
    logic        se;
    logic [47:0] res;
    logic [15:0] zpat;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    szb_static_zone_bus_timing szb_static_zone_bus_timing_inst (.pclk, .presetn, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .core_req, .core_addr, .core_write,
        .core_wide, .core_done, .zone0_select, .zone1_select_out_n, .zone2_select_out_n, .io_select_n,
        .bus_addr_phase, .internal_wait_cycle, .bus_data_phase, .burst_wait_cycle, .bus_hold_cycle,
        .bus_idle_cycle, .bus_write, .bus_byte_hi, .bus_wide);
    szb_core_model szb_core_model_inst (.pclk, .core_req, .core_addr, .core_write, .core_wide, .core_done,
        .internal_wait_cycle, .bus_data_phase, .burst_wait_cycle, .bus_hold_cycle, .bus_idle_cycle);

    // 50 MHz clock
    always #10 pclk = ~pclk;
    // Cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; index -1 is an unmapped address
    task automatic apb(input logic w, input int i, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= (i < 0) ? 32'h00000040 : 32'({REG_OFFSET[i], 2'b00});
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for pready; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
    endtask

    task automatic rchk(input int i, input logic x, input logic [15:0] e);
        apb(1'b0, i, 16'h0);
        cmp("register read", {15'h0, x, 16'h0, e}, {15'h0, se, rd});
    endtask

    task automatic core(input logic [23:0] a, input logic w, input logic wd, input logic [47:0] e);
        szb_core_model_inst.access(a, w, wd, res);
        cmp("core cycle", e, res);
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < NUM_REGS; i++) begin
            rchk(i, 1'b0, REG_RESET[i]);
            apb(1'b1, i, 16'hffff);
            rchk(i, 1'b0, REG_RESET[i] | REG_MASK[i]);
            zpat = (i == IDX_WRITE_CYCLE) ? 16'h0006 : ((i == IDX_STATIC0) ? 16'h0080 : 16'h0000);
            apb(1'b1, i, zpat);
            rchk(i, 1'b0, (REG_RESET[i] & ~REG_MASK[i]) | (zpat & REG_MASK[i]));
        end
        apb(1'b1, -1, 16'hffff);
        rchk(-1, 1'b1, 16'h0);
        apb(1'b1, IDX_WRITE_CYCLE, 16'h0006);
        rchk(IDX_WRITE_CYCLE, 1'b0, 16'h0006);
        $display("register test done");
        apb(1'b1, IDX_STATIC1, 16'h0089);
        core(24'h400000, 1'b1, 1'b0, 48'h060101000100);
        apb(1'b1, IDX_STATIC1, 16'h009f);
        core(24'h400002, 1'b0, 1'b0, 48'h0e0701000300);
        apb(1'b1, IDX_WRITE_CYCLE, 16'h0007);
        core(24'h400004, 1'b1, 1'b0, 48'h0f0701000300);
        apb(1'b1, IDX_WRITE_CYCLE, 16'h0006);
        apb(1'b1, IDX_STATIC0, 16'h089f);
        core(24'h000100, 1'b0, 1'b1, 48'h030001000000);
        apb(1'b1, IDX_STATIC2, 16'h0061);
        core(24'h800000, 1'b0, 1'b1, 48'h070102010000);
        apb(1'b1, IDX_STATIC2, 16'h0041);
        core(24'h800002, 1'b0, 1'b1, 48'h080202000000);
        $display("timing test done");
        apb(1'b1, IDX_STATIC1, 16'h0480);
        core(24'h400000, 1'b0, 1'b0, 48'h050001000001);
        core(24'h400004, 1'b0, 1'b0, 48'h040001000000);
        apb(1'b1, IDX_STATIC1, 16'h0280);
        core(24'h400008, 1'b0, 1'b0, 48'h040001000000);
        core(24'h800000, 1'b0, 1'b0, 48'h060101000001);
        core(24'hfffbff, 1'b0, 1'b0, 48'h040001000000);
        $display("idle test done");
        end_sim();
    end
endmodule

// [bench/szb_static_zone_bus_timing_chk.sv]
// Checker of bus phase order and cycle bounds at the block ports
`timescale 1ns/100ps
module szb_static_zone_bus_timing_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_done,
    input wire logic zone0_select,
    input wire logic zone1_select_out_n,
    input wire logic zone2_select_out_n,
    input wire logic io_select_n,
    input wire logic bus_addr_phase,
    input wire logic internal_wait_cycle,
    input wire logic bus_data_phase,
    input wire logic burst_wait_cycle,
    input wire logic bus_hold_cycle,
    input wire logic bus_idle_cycle,
    input wire logic bus_write,
    input wire logic bus_byte_hi,
    input wire logic bus_wide
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Active selects, active high
    wire logic [3:0] sel_vec = {zone0_select, ~zone1_select_out_n, ~zone2_select_out_n, ~io_select_n};
    // Phase order and cycle bounds
    a_wait_after_addr: assert property ($rose(internal_wait_cycle) |-> $past(bus_addr_phase))
        else $error("wait not after address");
    a_hold_after_data: assert property ($rose(bus_hold_cycle) |-> $past(bus_data_phase))
        else $error("hold not after data");
    a_wait_max_seven: assert property (internal_wait_cycle [*7] |=> !internal_wait_cycle)
        else $error("over seven waits");
    a_hold_max_three: assert property (bus_hold_cycle [*3] |=> !bus_hold_cycle)
        else $error("over three holds");
    a_idle_max_two: assert property (bus_idle_cycle [*2] |=> !bus_idle_cycle)
        else $error("over two idles");
    a_burst_wait_gap: assert property (burst_wait_cycle |-> $past(bus_data_phase) ##1 bus_data_phase)
        else $error("burst wait outside burst");
    a_select_onehot: assert property ($onehot0(sel_vec))
        else $error("two selects");
    a_wait_hold_selected: assert property (internal_wait_cycle || bus_hold_cycle |-> |sel_vec)
        else $error("wait or hold unselected");
    a_early_addr_write: assert property (bus_addr_phase ##1 bus_addr_phase |-> bus_write)
        else $error("long address on read");
    a_byte_hi_narrow: assert property (bus_byte_hi |-> !bus_wide)
        else $error("second byte on wide zone");
    cover property (bus_byte_hi);
    cover property (burst_wait_cycle);
    cover property (bus_idle_cycle);
    cover property (core_done);
endmodule

bind szb_static_zone_bus_timing szb_static_zone_bus_timing_chk szb_static_zone_bus_timing_chk_inst (
    .pclk, .presetn, .core_done, .zone0_select, .zone1_select_out_n, .zone2_select_out_n,
    .io_select_n, .bus_addr_phase, .internal_wait_cycle, .bus_data_phase, .burst_wait_cycle,
    .bus_hold_cycle, .bus_idle_cycle, .bus_write, .bus_byte_hi, .bus_wide);

// [core/szb_cfg_reg.sv]
// One configuration register with per-byte writes and fixed reserved bits
`timescale 1ns/100ps
module szb_cfg_reg #(
    parameter logic [15:0] RST  = 16'h0000,
    parameter logic [15:0] MASK = 16'hffff
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic [1:0]  wr_be,
    input  wire logic [15:0] wdata,
    output logic      [15:0] value_q
);
    logic [15:0] lane_mask;

    // Writable bits that the active byte lanes touch
    assign lane_mask = MASK & {{8{wr_be[1]}}, {8{wr_be[0]}}};

    // Reserved bits keep their reset value forever
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= RST;
        end else if (clk_en) begin
            value_q <= (wdata & lane_mask) | (value_q & ~lane_mask);
        end
    end
endmodule

// [core/szb_down_cnt.sv]
// Small loadable down counter for wait and hold cycles
`timescale 1ns/100ps
module szb_down_cnt #(
    parameter int W = 3
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clk_en,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         dec,
    output logic      [W-1:0] cnt_q,
    output logic              zero
);
    // Refuse a counter with no bits at elaboration
    if (W < 1) begin : g_bad_width
        $error("szb_down_cnt: W must be at least 1");
    end

    assign zero = (cnt_q == '0);

    // Load wins over decrement; stops at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (load) begin
                cnt_q <= load_val;
            end else if (dec && !zero) begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end
endmodule

// [core/szb_pkg.sv]
// Package for the static zone bus timing block: map, fields, zones and states
// Function
// - Write-cycle configuration resets to 07h, selecting early-write cycles.
// - Bit 0 picks write timing: 0 late write of two clocks, 1 early write.
// - I/O zone configuration is 16 bits, covers FF FB00h-FF FBFFh, resets 069Fh.
// - Three-bit wait field adds zero to seven internal wait cycles per access.
// - Two-bit hold field sets zero to three hold cycles per access.
// - Bit 7 picks zone bus width: 0 is 8-bit, 1 is 16-bit.
// - Post-idle bit 9 adds one idle cycle after, when next zone differs.
// - Pre-idle bit 10 adds one idle cycle before, when zone differs.
// - Static zone 0 configuration governs on-chip flash and resets to 069Fh.
// - Fast-read bit 11 makes reads one clock; otherwise at least two.
// - Wait and hold fields have no effect while fast read is set.
// - Read-burst bit 5 bursts 16-bit reads on 8-bit zones, not when fast.
// - Burst-wait bit 6 adds one burst wait cycle, only in bursts.
// - Static zone 1 configuration at FF F906h times zone 1 select accesses.
// - Static zone 2 configuration at FF F908h times zone 2 select accesses.
// - Wait cycles follow the address; hold cycles end the cycle.
package szb_pkg;

    localparam int NUM_REGS = 5;
    localparam int IDX_WRITE_CYCLE = 0;
    localparam int IDX_IO_ZONE     = 1;
    localparam int IDX_STATIC0     = 2;
    localparam int IDX_STATIC1     = 3;
    localparam int IDX_STATIC2     = 4;

    // Register addresses; the APB byte address is four times the register address
    localparam logic [23:0] OFF_WRITE_CYCLE_CONFIG  = 24'hfff900;
    localparam logic [23:0] OFF_IO_ZONE_CONFIG      = 24'hfff902;
    localparam logic [23:0] OFF_STATIC_ZONE0_CONFIG = 24'hfff904;
    localparam logic [23:0] OFF_STATIC_ZONE1_CONFIG = 24'hfff906;
    localparam logic [23:0] OFF_STATIC_ZONE2_CONFIG = 24'hfff908;
    localparam logic [23:0] REG_OFFSET [NUM_REGS] = '{OFF_WRITE_CYCLE_CONFIG, OFF_IO_ZONE_CONFIG,
        OFF_STATIC_ZONE0_CONFIG, OFF_STATIC_ZONE1_CONFIG, OFF_STATIC_ZONE2_CONFIG};

    // Reset values and writable-bit masks
    localparam logic [15:0] RST_WRITE_CYCLE = 16'h0007;
    localparam logic [15:0] RST_ZONE        = 16'h069f;
    localparam logic [15:0] MASK_WRITE_CYCLE = 16'h0001;
    localparam logic [15:0] MASK_IO_ZONE     = 16'h029f;
    localparam logic [15:0] MASK_STATIC      = 16'h0eff;
    localparam logic [15:0] REG_RESET [NUM_REGS] = '{RST_WRITE_CYCLE, RST_ZONE, RST_ZONE, RST_ZONE, RST_ZONE};
    localparam logic [15:0] REG_MASK [NUM_REGS] = '{MASK_WRITE_CYCLE, MASK_IO_ZONE,
        MASK_STATIC, MASK_STATIC, MASK_STATIC};

    // Field positions
    localparam int BIT_EARLY_WRITE = 0;
    localparam int WAIT_LSB        = 0;
    localparam int HOLD_LSB        = 3;
    localparam int BIT_BURST_READ  = 5;
    localparam int BIT_BURST_WAIT  = 6;
    localparam int BIT_BUS_WIDTH   = 7;
    localparam int BIT_POST_IDLE   = 9;
    localparam int BIT_PRE_IDLE    = 10;
    localparam int BIT_FAST_READ   = 11;

    // Zone address ranges
    localparam logic [23:0] Z0_PROG_LO = 24'h000000;
    localparam logic [23:0] Z0_PROG_HI = 24'h03ffff;
    localparam logic [23:0] Z0_DATA_LO = 24'h0d0000;
    localparam logic [23:0] Z0_DATA_HI = 24'h0d1fff;
    localparam logic [23:0] Z1_LO      = 24'h400000;
    localparam logic [23:0] Z1_HI      = 24'h7fffff;
    localparam logic [23:0] Z2_LO      = 24'h800000;
    localparam logic [23:0] Z2_HI      = 24'hfeffff;
    localparam logic [23:0] IO_LO      = 24'hfffb00;
    localparam logic [23:0] IO_HI      = 24'hfffbff;

    typedef enum logic [2:0] {ZN_IO, ZN_STATIC0, ZN_STATIC1, ZN_STATIC2, ZN_NONE} szb_zone_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_POST, ST_PRE, ST_ADDR, ST_EARLY, ST_WAIT, ST_DATA, ST_BWAIT, ST_HOLD
    } szb_state_t;

    // Zone that an address falls in
    function automatic szb_zone_t zone_of(input logic [23:0] a);
        if ((a >= Z0_PROG_LO && a <= Z0_PROG_HI) || (a >= Z0_DATA_LO && a <= Z0_DATA_HI)) begin
            return ZN_STATIC0;
        end else if (a >= Z1_LO && a <= Z1_HI) begin
            return ZN_STATIC1;
        end else if (a >= Z2_LO && a <= Z2_HI) begin
            return ZN_STATIC2;
        end else if (a >= IO_LO && a <= IO_HI) begin
            return ZN_IO;
        end
        return ZN_NONE;
    endfunction

endpackage

// [core/szb_static_zone_bus_timing.sv]
// Top: APB configuration registers and the per-zone bus cycle sequencer
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
module szb_static_zone_bus_timing (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        core_req,
    input  wire logic [23:0] core_addr,
    input  wire logic        core_write,
    input  wire logic        core_wide,
    output logic             core_done,
    output logic             zone0_select,
    output logic             zone1_select_out_n,
    output logic             zone2_select_out_n,
    output logic             io_select_n,
    output logic             bus_addr_phase,
    output logic             internal_wait_cycle,
    output logic             bus_data_phase,
    output logic             burst_wait_cycle,
    output logic             bus_hold_cycle,
    output logic             bus_idle_cycle,
    output logic             bus_write,
    output logic             bus_byte_hi,
    output logic             bus_wide
);
    import szb_pkg::*;

    logic [15:0] cfg [NUM_REGS];
    logic [1:0]  reg_be [NUM_REGS];
    logic [NUM_REGS-1:0] hit;
    logic        mapped;
    logic [15:0] rd_mux;
    logic        wr_fire;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    // Address match for each register
    always_comb begin
        hit = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            hit[i] = (paddr == {6'h00, REG_OFFSET[i], 2'b00});
        end
    end

    assign mapped = |hit;

    // Read mux of the addressed register
    always_comb begin
        rd_mux = 16'h0000;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_mux = cfg[i];
            end
        end
    end

    // Write takes effect at the edge that closes the access phase
    assign wr_fire = psel && penable && pwrite && pready_q && !pslverr_q && clk_en;

    // Configuration registers
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_cfg
        assign reg_be[g] = (wr_fire && hit[g]) ? pstrb[1:0] : 2'b00;
        szb_cfg_reg #(
            .RST  (REG_RESET[g]),
            .MASK (REG_MASK[g])
        ) u_reg (
            .pclk    (pclk),
            .presetn (presetn),
            .clk_en  (clk_en),
            .wr_be   (reg_be[g]),
            .wdata   (pwdata[15:0]),
            .value_q (cfg[g])
        );
    end

    // APB answer: ready in the first access cycle, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata_q <= (mapped && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // Configuration of a zone
    function automatic logic [15:0] cfg_of(input szb_zone_t z);
        case (z)
            ZN_IO:      return cfg[IDX_IO_ZONE];
            ZN_STATIC0: return cfg[IDX_STATIC0];
            ZN_STATIC1: return cfg[IDX_STATIC1];
            ZN_STATIC2: return cfg[IDX_STATIC2];
            default:    return 16'h0000;
        endcase
    endfunction

    // Sequencer state
    szb_state_t  state_q, state_d;
    szb_zone_t   zone_q, zone_d, last_zone_q, new_zone;
    logic [15:0] cur_cfg_q, cur_cfg_d, new_cfg;
    logic        wr_q, wr_d, wide_q, wide_d;
    logic        byte_hi_q, byte_hi_d;
    logic        post_pend_q;
    logic        done_d, done_q;
    logic        start;
    logic        cnt_load, cnt_dec, cnt_zero;
    logic [2:0]  cnt_val, cnt_q;

    // Effective settings of the cycle in progress and of the one requested
    logic        is_static, fast_read_enable, burst, bwait, pre_idle_enable, early, bus16, fast_rd;
    logic [2:0]  wait_n;
    logic [1:0]  hold_n;
    logic        new_pre_idle_enable, new_fast;

    assign new_zone = zone_of(core_addr);
    assign new_cfg  = cfg_of(new_zone);
    assign start    = core_req && !done_q;

    assign is_static = (zone_q == ZN_STATIC0) || (zone_q == ZN_STATIC1) || (zone_q == ZN_STATIC2);
    assign fast_read_enable     = is_static && cur_cfg_q[BIT_FAST_READ];
    assign fast_rd = fast_read_enable && !wr_q;
    assign wait_n  = fast_read_enable ? 3'd0 : cur_cfg_q[WAIT_LSB +: 3];
    assign hold_n  = fast_read_enable ? 2'd0 : cur_cfg_q[HOLD_LSB +: 2];
    assign bus16   = cur_cfg_q[BIT_BUS_WIDTH] || zone_q == ZN_NONE;
    assign burst   = is_static && !fast_read_enable && cur_cfg_q[BIT_BURST_READ] && !bus16 && !wr_q && wide_q;
    assign bwait   = burst && cur_cfg_q[BIT_BURST_WAIT];
    assign pre_idle_enable    = is_static && cur_cfg_q[BIT_PRE_IDLE];
    assign early   = cfg[IDX_WRITE_CYCLE][BIT_EARLY_WRITE];

    assign new_pre_idle_enable = (new_zone != ZN_IO) && (new_zone != ZN_NONE) && new_cfg[BIT_PRE_IDLE];
    assign new_fast = (new_zone != ZN_IO) && (new_zone != ZN_NONE) && new_cfg[BIT_FAST_READ] && !core_write;

    // Next state of the bus cycle
    always_comb begin
        state_d   = state_q;
        zone_d    = zone_q;
        cur_cfg_d = cur_cfg_q;
        wr_d      = wr_q;
        wide_d    = wide_q;
        byte_hi_d = byte_hi_q;
        done_d    = 1'b0;
        cnt_load  = 1'b0;
        cnt_val   = 3'd0;
        cnt_dec   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    zone_d    = new_zone;
                    cur_cfg_d = new_cfg;
                    wr_d      = core_write;
                    wide_d    = core_wide;
                    byte_hi_d = 1'b0;
                    if (new_zone != last_zone_q && post_pend_q) begin
                        state_d = ST_POST;
                    end else if (new_zone != last_zone_q && new_pre_idle_enable) begin
                        state_d = ST_PRE;
                    end else if (new_fast || new_zone == ZN_NONE) begin
                        state_d = ST_DATA;
                    end else begin
                        state_d = ST_ADDR;
                    end
                end
            end
            ST_POST: begin
                if (pre_idle_enable) begin
                    state_d = ST_PRE;
                end else if (fast_rd || zone_q == ZN_NONE) begin
                    state_d = ST_DATA;
                end else begin
                    state_d = ST_ADDR;
                end
            end
            ST_PRE: begin
                state_d = (fast_rd || zone_q == ZN_NONE) ? ST_DATA : ST_ADDR;
            end
            ST_ADDR, ST_EARLY: begin
                if (state_q == ST_ADDR && wr_q && early) begin
                    state_d = ST_EARLY;
                end else if (wait_n != 3'd0) begin
                    state_d  = ST_WAIT;
                    cnt_load = 1'b1;
                    cnt_val  = wait_n - 3'd1;
                end else begin
                    state_d = ST_DATA;
                end
            end
            ST_WAIT: begin
                cnt_dec = 1'b1;
                if (cnt_zero) begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (burst && !byte_hi_q) begin
                    byte_hi_d = 1'b1;
                    state_d   = bwait ? ST_BWAIT : ST_DATA;
                end else if (hold_n != 2'd0) begin
                    state_d  = ST_HOLD;
                    cnt_load = 1'b1;
                    cnt_val  = {1'b0, hold_n - 2'd1};
                end else if (wide_q && !bus16 && !byte_hi_q) begin
                    byte_hi_d = 1'b1;
                    state_d   = fast_rd ? ST_DATA : ST_ADDR;
                end else begin
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_BWAIT: begin
                state_d = ST_DATA;
            end
            ST_HOLD: begin
                cnt_dec = 1'b1;
                if (cnt_zero) begin
                    if (wide_q && !bus16 && !byte_hi_q) begin
                        byte_hi_d = 1'b1;
                        state_d   = ST_ADDR;
                    end else begin
                        done_d  = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    szb_down_cnt #(
        .W (3)
    ) u_cnt (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .load     (cnt_load),
        .load_val (cnt_val),
        .dec      (cnt_dec),
        .cnt_q    (cnt_q),
        .zero     (cnt_zero)
    );

    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ST_IDLE;
            zone_q    <= ZN_NONE;
            cur_cfg_q <= 16'h0000;
            wr_q      <= 1'b0;
            wide_q    <= 1'b0;
            byte_hi_q <= 1'b0;
            done_q    <= 1'b0;
        end else if (clk_en) begin
            state_q   <= state_d;
            zone_q    <= zone_d;
            cur_cfg_q <= cur_cfg_d;
            wr_q      <= wr_d;
            wide_q    <= wide_d;
            byte_hi_q <= byte_hi_d;
            done_q    <= done_d;
        end
    end

    // Zone history for idle-cycle decisions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_zone_q <= ZN_NONE;
            post_pend_q <= 1'b0;
        end else if (clk_en && done_d) begin
            last_zone_q <= zone_q;
            post_pend_q <= (zone_q != ZN_NONE) && cur_cfg_q[BIT_POST_IDLE];
        end
    end

    // Registered bus outputs decoded from the next state
    logic sel_act_d;
    logic [13:0] out_q;

    assign sel_act_d = (state_d != ST_IDLE) && (state_d != ST_POST) && (state_d != ST_PRE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 14'h001c;
        end else if (clk_en) begin
            out_q[0]  <= done_d;
            out_q[1]  <= sel_act_d && zone_d == ZN_STATIC0;
            out_q[2]  <= !(sel_act_d && zone_d == ZN_STATIC1);
            out_q[3]  <= !(sel_act_d && zone_d == ZN_STATIC2);
            out_q[4]  <= !(sel_act_d && zone_d == ZN_IO);
            out_q[5]  <= state_d == ST_ADDR || state_d == ST_EARLY;
            out_q[6]  <= state_d == ST_WAIT;
            out_q[7]  <= state_d == ST_DATA;
            out_q[8]  <= state_d == ST_BWAIT;
            out_q[9]  <= state_d == ST_HOLD;
            out_q[10] <= state_d == ST_POST || state_d == ST_PRE;
            out_q[11] <= sel_act_d && wr_d;
            out_q[12] <= sel_act_d && byte_hi_d;
            out_q[13] <= sel_act_d && cur_cfg_d[BIT_BUS_WIDTH];
        end
    end

    assign core_done           = out_q[0];
    assign zone0_select        = out_q[1];
    assign zone1_select_out_n  = out_q[2];
    assign zone2_select_out_n  = out_q[3];
    assign io_select_n         = out_q[4];
    assign bus_addr_phase      = out_q[5];
    assign internal_wait_cycle = out_q[6];
    assign bus_data_phase      = out_q[7];
    assign burst_wait_cycle    = out_q[8];
    assign bus_hold_cycle      = out_q[9];
    assign bus_idle_cycle      = out_q[10];
    assign bus_write           = out_q[11];
    assign bus_byte_hi         = out_q[12];
    assign bus_wide            = out_q[13];
endmodule
